// [dv/ctrb_wb_master.sv]
// Purpose: classic Wishbone master standing in for the fieldbus master
// Assumes: slave answers every request with ack or err
// Notes:   released lines show inverted values, never the last request
`timescale 1ns/1ns
module ctrb_wb_master (
  input  wire logic        clk,
  input  wire logic        ack,
  input  wire logic        err,
  input  wire logic [31:0] dat_i,
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic      [31:0] adr,
  output logic      [3:0]  sel,
  output logic      [31:0] dat_o
);
  initial begin
    cyc   = 1'b0;
    stb   = 1'b0;
    we    = 1'b0;
    adr   = 32'h00000000;
    sel   = 4'h0;
    dat_o = 32'h00000000;
  end

  // ---------------------------------------------------------------
  // one classic cycle, entered just after a rising edge
  // ---------------------------------------------------------------
  task automatic access(input logic w, input logic [31:0] a, input logic [15:0] wd,
                        input logic [3:0] s, output logic [31:0] rd, output logic er);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    sel   <= s;
    dat_o <= {16'h0000, wd};
    @(posedge clk);
    while (ack !== 1'b1 && err !== 1'b1) begin
      @(posedge clk);
    end
    rd    = dat_i;
    er    = err;
    cyc   <= 1'b0;
    stb   <= 1'b0;
    we    <= ~w;
    adr   <= ~a;
    sel   <= ~s;
    dat_o <= ~{16'h0000, wd};
    // idle cycle so the held request is never taken twice
    @(posedge clk);
  endtask

  // byte-reversed test word means the swapped word format is active
  function automatic logic swapped(input logic [15:0] w);
    return w === 16'h3412;
  endfunction
endmodule

// [dv/tb_ctrb_top.sv]
// Purpose: self-checking bench of the constant test register bank
// Assumes: small retain window so the top index stays reachable
// Notes:   all traffic goes through the master model tasks
`timescale 1ns/1ns
module tb_ctrb_top;
  localparam int DEPTH = 64;
  logic        core_clk;
  logic        reset;
  wire logic   cyc;
  wire logic   stb;
  wire logic   we;
  wire logic   ack;
  wire logic   err;
  wire logic [31:0] adr;
  wire logic [31:0] dwr;
  wire logic [31:0] drd;
  wire logic [3:0]  sel;
  int          mismatches;
  int          cmp_count;
  logic [31:0] rd;
  logic        er;
  logic [15:0] got [9];
  logic [15:0] exp_c [9] = '{16'h0000, 16'hFFFF, 16'h1234, 16'hAAAA, 16'h5555,
                             16'h7FFF, 16'h8000, 16'h3FFF, 16'hC000};
  logic [31:0] bad_a [3] = '{32'h00008024, 32'h0000C000 + 32'(4 * DEPTH), 32'h0002C000};

  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  ctrb_top #(.RET_DEPTH(DEPTH)) uut (
    .CORE_CLK(core_clk), .RESET(reset), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dwr), .WB_DAT_O(drd), .WB_ACK_O(ack),
    .WB_ERR_O(err)
  );
  ctrb_wb_master m (
    .clk(core_clk), .ack(ack), .err(err), .dat_i(drd), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .sel(sel), .dat_o(dwr)
  );

  // ---------------------------------------------------------------
  // compare and verdict
  // ---------------------------------------------------------------
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    reset      = 1'b1;
    mismatches = 0;
    cmp_count  = 0;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    check({ack, err, drd}, 34'h0);
    for (int i = 0; i < 9; i++) begin
      m.access(1'b0, 32'h8000 + 32'(4 * i), 16'h0000, 4'hF, rd, er);
      check(34'(rd), 34'({16'h0000, exp_c[i]}));
      check(34'(er), 34'h0);
      got[i] = rd[15:0];
    end
    check(34'(got[3] ^ got[4]), 34'h0FFFF);
    check(34'(m.swapped(got[2])), 34'h0);
    check(34'(m.swapped({got[2][7:0], got[2][15:8]})), 34'h1);
    $display("test constant reads done");
    // complement written so a leaking write cannot look unchanged
    for (int i = 0; i < 9; i++) begin
      m.access(1'b1, 32'h8000 + 32'(4 * i), ~exp_c[i], 4'hF, rd, er);
      check(34'({er, rd}), 34'h0);
      m.access(1'b0, 32'h8000 + 32'(4 * i), 16'h0000, 4'hF, rd, er);
      check(34'(rd), 34'({16'h0000, exp_c[i]}));
    end
    $display("test constant writes done");
    m.access(1'b1, 32'hC000, 16'hA55A, 4'h3, rd, er);
    m.access(1'b1, 32'hC000 + 32'(4 * (DEPTH - 1)), 16'h0FF0, 4'h3, rd, er);
    check(34'(er), 34'h0);
    // read straight after a full write, so the readback assertion is armed
    m.access(1'b0, 32'hC000 + 32'(4 * (DEPTH - 1)), 16'h0000, 4'hF, rd, er);
    check(34'(rd), 34'h00FF0);
    m.access(1'b1, 32'hC000, 16'h1111, 4'h1, rd, er);
    m.access(1'b0, 32'hC000, 16'h0000, 4'hF, rd, er);
    check(34'(rd), 34'h0A511);
    m.access(1'b1, 32'hC000, 16'h2222, 4'h2, rd, er);
    m.access(1'b0, 32'hC000, 16'h0000, 4'hF, rd, er);
    check(34'(rd), 34'h02211);
    $display("test retain window done");
    for (int i = 0; i < 3; i++) begin
      m.access(1'b1, bad_a[i], 16'hFFFF, 4'hF, rd, er);
      check(34'({er, rd}), 34'h100000000);
      m.access(1'b0, bad_a[i], 16'h0000, 4'hF, rd, er);
      check(34'({er, rd}), 34'h100000000);
    end
    m.access(1'b0, 32'hC000, 16'h0000, 4'hF, rd, er);
    check(34'(rd), 34'h02211);
    $display("test unmapped done");
    print_verdict();
  end

  // ---------------------------------------------------------------
  // watchdog, far beyond the roughly 130 cycles the tests need
  // ---------------------------------------------------------------
  initial begin
    repeat (4000) @(posedge core_clk);
    mismatches++;
    print_verdict();
  end
endmodule

// [verilog/ctrb_cfg.svh]
`ifndef CTRB_CFG_SVH
`define CTRB_CFG_SVH
// Purpose: offsets, values and sizes of the constant test register bank
// Assumes: word index = byte address / 4, data in the low 16 bits
// Notes:   definitions only

// ---------------------------------------------------------------
// word indices and retain depth
// ---------------------------------------------------------------
`define CTRB_IDX_ZERO     15'h2000
`define CTRB_IDX_ONES     15'h2001
`define CTRB_IDX_ORDER    15'h2002
`define CTRB_IDX_MASK_HI  15'h2003
`define CTRB_IDX_MASK_LO  15'h2004
`define CTRB_IDX_MAX_POS  15'h2005
`define CTRB_IDX_MAX_NEG  15'h2006
`define CTRB_IDX_HALF_POS 15'h2007
`define CTRB_IDX_HALF_NEG 15'h2008
`define CTRB_IDX_RET_LO   15'h3000
`define CTRB_IDX_RET_HI   15'h5FFF
`define CTRB_RET_DEPTH    12288

// ---------------------------------------------------------------
// constant values
// ---------------------------------------------------------------
`define CTRB_VAL_ZERO     16'h0000
`define CTRB_VAL_ONES     16'hFFFF
`define CTRB_VAL_ORDER    16'h1234
`define CTRB_VAL_MASK_HI  16'hAAAA
`define CTRB_VAL_MASK_LO  16'h5555
`define CTRB_VAL_MAX_POS  16'h7FFF
`define CTRB_VAL_MAX_NEG  16'h8000
`define CTRB_VAL_HALF_POS 16'h3FFF
`define CTRB_VAL_HALF_NEG 16'hC000
`endif

// [verilog/ctrb_const_rom.sv]
// Purpose: decode of the fixed test words
// Assumes: index already stripped of byte bits
// Notes:   purely combinational, no storage
`timescale 1ns/1ns
`include "ctrb_cfg.svh"
module ctrb_const_rom (
  input  wire ctrb_pkg::ctrb_idx_t  idx,
  output wire                       hit,
  output wire ctrb_pkg::ctrb_word_t value
);
  // ---------------------------------------------------------------
  // lookup
  // ---------------------------------------------------------------
  function automatic logic [16:0] lookup(input ctrb_pkg::ctrb_idx_t i);
    case (i)
      `CTRB_IDX_ZERO:     lookup = {1'b1, `CTRB_VAL_ZERO};
      `CTRB_IDX_ONES:     lookup = {1'b1, `CTRB_VAL_ONES};
      `CTRB_IDX_ORDER:    lookup = {1'b1, `CTRB_VAL_ORDER};
      `CTRB_IDX_MASK_HI:  lookup = {1'b1, `CTRB_VAL_MASK_HI};
      `CTRB_IDX_MASK_LO:  lookup = {1'b1, `CTRB_VAL_MASK_LO};
      `CTRB_IDX_MAX_POS:  lookup = {1'b1, `CTRB_VAL_MAX_POS};
      `CTRB_IDX_MAX_NEG:  lookup = {1'b1, `CTRB_VAL_MAX_NEG};
      `CTRB_IDX_HALF_POS: lookup = {1'b1, `CTRB_VAL_HALF_POS};
      `CTRB_IDX_HALF_NEG: lookup = {1'b1, `CTRB_VAL_HALF_NEG};
      default:            lookup = 17'h00000;
    endcase
  endfunction

  wire [16:0] found;
  assign found = lookup(idx);
  assign hit   = found[16];
  assign value = found[15:0];
endmodule

// [verilog/ctrb_pkg.sv]
// Purpose: shared types of the constant test register bank
// Assumes: nothing
// Notes:   values live in ctrb_cfg.svh
package ctrb_pkg;
  typedef logic [15:0] ctrb_word_t;
  typedef logic [14:0] ctrb_idx_t;
  typedef enum logic [1:0] {
    CTRB_ST_IDLE,
    CTRB_ST_ACK,
    CTRB_ST_ERR
  } ctrb_bus_st_t;
endpackage

// [verilog/ctrb_retain_mem.sv]
// Purpose: flip-flop storage of the retain window
// Assumes: one write port with byte lanes, one asynchronous read port
// Notes:   not reset, contents survive a bus reset
`timescale 1ns/1ns
module ctrb_retain_mem #(
  parameter int DEPTH = 12288,
  parameter int W     = 16,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             clk,
  input  wire logic             we,
  input  wire logic [W/8-1:0]   be,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [W-1:0]     wdata,
  input  wire logic [AW-1:0]    raddr,
  output wire logic [W-1:0]     rdata
);
  logic [W-1:0] mem_r [DEPTH];
  wire  [W-1:0] lane_mask;

  // ---------------------------------------------------------------
  // byte lanes
  // ---------------------------------------------------------------
  for (genvar g = 0; g < W/8; g++) begin : g_lane
    assign lane_mask[g*8 +: 8] = {8{be[g]}};
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem_r[waddr] <= (mem_r[waddr] & ~lane_mask) | (wdata & lane_mask);
    end
  end

  assign rdata = mem_r[raddr];
endmodule

// [verilog/ctrb_top.sv]
// Purpose: classic Wishbone slave holding constant test words and retain storage
// Assumes: one clock, synchronous reset, 32-bit bus, word per index
// Notes:   one request answered per ack or err, next cycle after it is taken
`timescale 1ns/1ns
`include "ctrb_cfg.svh"
module ctrb_top #(
  parameter int RET_DEPTH = `CTRB_RET_DEPTH
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RESET,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [31:0] WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output wire logic [31:0] WB_DAT_O,
  output wire logic        WB_ACK_O,
  output wire logic        WB_ERR_O
);
  localparam int AW = $clog2(RET_DEPTH);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  ctrb_pkg::ctrb_bus_st_t st_r;
  ctrb_pkg::ctrb_bus_st_t st_nxt;
  ctrb_pkg::ctrb_word_t   dat_r;
  ctrb_pkg::ctrb_word_t   dat_nxt;

  wire ctrb_pkg::ctrb_idx_t  idx;
  wire ctrb_pkg::ctrb_word_t const_val;
  wire ctrb_pkg::ctrb_word_t ret_rdata;
  wire                       const_hit;
  wire                       upper_zero;
  wire                       ret_in_win;
  wire                       ret_hit;
  wire                       mapped;
  wire                       take;
  wire                       mem_we;
  wire [14:0]                ret_off;
  wire [AW-1:0]              ret_addr;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // low two address bits are byte bits; lanes come from sel
  assign idx        = WB_ADR_I[16:2];
  assign upper_zero = (WB_ADR_I[31:17] == 15'h0000);
  assign ret_off    = idx - `CTRB_IDX_RET_LO;
  assign ret_addr   = ret_off[AW-1:0];

  // a smaller depth leaves the top of the window unmapped
  assign ret_in_win = (idx >= `CTRB_IDX_RET_LO) && (idx <= `CTRB_IDX_RET_HI);
  assign ret_hit    = upper_zero && ret_in_win && (32'(ret_off) < RET_DEPTH);
  assign mapped     = (upper_zero && const_hit) || ret_hit;

  // ---------------------------------------------------------------
  // constant words
  // ---------------------------------------------------------------
  ctrb_const_rom u_const (
    .idx   (idx),
    .hit   (const_hit),
    .value (const_val)
  );

  // ---------------------------------------------------------------
  // retain storage
  // ---------------------------------------------------------------
  // only the retain window may be written; constant writes fall away here
  assign mem_we = take && WB_WE_I && ret_hit;

  ctrb_retain_mem #(
    .DEPTH (RET_DEPTH),
    .W     (16),
    .AW    (AW)
  ) u_ret (
    .clk   (CORE_CLK),
    .we    (mem_we),
    .be    (WB_SEL_I[1:0]),
    .waddr (ret_addr),
    .wdata (WB_DAT_I[15:0]),
    .raddr (ret_addr),
    .rdata (ret_rdata)
  );

  // ---------------------------------------------------------------
  // bus handshake
  // ---------------------------------------------------------------
  // idle guard keeps a held request from being taken twice
  assign take = WB_CYC_I && WB_STB_I && (st_r == ctrb_pkg::CTRB_ST_IDLE);

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ctrb_pkg::CTRB_ST_IDLE: begin
        if (take) begin
          st_nxt = mapped ? ctrb_pkg::CTRB_ST_ACK : ctrb_pkg::CTRB_ST_ERR;
        end
      end
      ctrb_pkg::CTRB_ST_ACK: st_nxt = ctrb_pkg::CTRB_ST_IDLE;
      ctrb_pkg::CTRB_ST_ERR: st_nxt = ctrb_pkg::CTRB_ST_IDLE;
      default:               st_nxt = ctrb_pkg::CTRB_ST_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  // writes and errors answer with zero so stale data never shows
  always_comb begin
    dat_nxt = 16'h0000;
    if (take && !WB_WE_I && upper_zero && const_hit) begin
      dat_nxt = const_val;
    end else if (take && !WB_WE_I && ret_hit) begin
      dat_nxt = ret_rdata;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      st_r  <= ctrb_pkg::CTRB_ST_IDLE;
      dat_r <= 16'h0000;
    end else begin
      st_r  <= st_nxt;
      dat_r <= dat_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // constants are 16 bits; upper lanes read as zero
  assign WB_DAT_O = {16'h0000, dat_r};
  assign WB_ACK_O = (st_r == ctrb_pkg::CTRB_ST_ACK);
  assign WB_ERR_O = (st_r == ctrb_pkg::CTRB_ST_ERR);

  // ---------------------------------------------------------------
  // checking helpers
  // ---------------------------------------------------------------
  logic        hlp_wr_vld_r;
  logic [14:0] hlp_wr_idx_r;
  logic [15:0] hlp_wr_dat_r;
  logic        hlp_mask_pend_r;
  logic        hlp_mask_vld_r;
  logic [15:0] hlp_mask_r;

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      hlp_wr_vld_r <= 1'b0;
      hlp_wr_idx_r <= 15'h0000;
      hlp_wr_dat_r <= 16'h0000;
    end else if (mem_we && (WB_SEL_I[1:0] == 2'h3)) begin
      hlp_wr_vld_r <= 1'b1;
      hlp_wr_idx_r <= idx;
      hlp_wr_dat_r <= WB_DAT_I[15:0];
    end else if (take && WB_WE_I) begin
      hlp_wr_vld_r <= 1'b0;
    end
  end

  // remembers the high mask as it was delivered on the bus, not as decoded
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      hlp_mask_pend_r <= 1'b0;
      hlp_mask_vld_r  <= 1'b0;
      hlp_mask_r      <= 16'h0000;
    end else begin
      hlp_mask_pend_r <= take && !WB_WE_I && (idx == `CTRB_IDX_MASK_HI) && upper_zero;
      if (hlp_mask_pend_r && WB_ACK_O) begin
        hlp_mask_vld_r <= 1'b1;
        hlp_mask_r     <= WB_DAT_O[15:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  sequence s_rd(ctrb_pkg::ctrb_idx_t i);
    take && !WB_WE_I && upper_zero && (idx == i);
  endsequence

  sequence s_ans(ctrb_pkg::ctrb_word_t v);
    WB_ACK_O && !WB_ERR_O && (WB_DAT_O == {16'h0000, v});
  endsequence

  sequence s_release;
    !WB_ACK_O && !WB_ERR_O;
  endsequence

  property p_const_ack;
    (take && upper_zero && const_hit) |=> (WB_ACK_O && !WB_ERR_O) ##1 s_release;
  endproperty
  a_const_ack: assert property (p_const_ack)
    else $error("constant access not acked for one cycle");

  property p_zero_word;
    s_rd(`CTRB_IDX_ZERO) |=> s_ans(`CTRB_VAL_ZERO);
  endproperty
  a_zero_word: assert property (p_zero_word)
    else $error("zero word wrong");

  property p_ones_word;
    s_rd(`CTRB_IDX_ONES) |=> s_ans(`CTRB_VAL_ONES);
  endproperty
  a_ones_word: assert property (p_ones_word)
    else $error("ones word wrong");

  property p_order_word;
    s_rd(`CTRB_IDX_ORDER) |=> s_ans(`CTRB_VAL_ORDER);
  endproperty
  a_order_word: assert property (p_order_word)
    else $error("byte order word wrong");

  property p_mask_hi;
    s_rd(`CTRB_IDX_MASK_HI) |=> s_ans(`CTRB_VAL_MASK_HI);
  endproperty
  a_mask_hi: assert property (p_mask_hi)
    else $error("high mask wrong");

  property p_mask_pair;
    (s_rd(`CTRB_IDX_MASK_LO) and hlp_mask_vld_r) |=>
      WB_ACK_O && ((WB_DAT_O[15:0] ^ hlp_mask_r) == 16'hFFFF);
  endproperty
  a_mask_pair: assert property (p_mask_pair)
    else $error("masks not complementary");

  property p_max_pos;
    s_rd(`CTRB_IDX_MAX_POS) |=> s_ans(`CTRB_VAL_MAX_POS);
  endproperty
  a_max_pos: assert property (p_max_pos)
    else $error("max positive wrong");

  property p_max_neg;
    s_rd(`CTRB_IDX_MAX_NEG) |=> s_ans(`CTRB_VAL_MAX_NEG);
  endproperty
  a_max_neg: assert property (p_max_neg)
    else $error("max negative wrong");

  property p_half_pos;
    s_rd(`CTRB_IDX_HALF_POS) |=> s_ans(`CTRB_VAL_HALF_POS);
  endproperty
  a_half_pos: assert property (p_half_pos)
    else $error("half positive wrong");

  property p_half_neg;
    s_rd(`CTRB_IDX_HALF_NEG) |=> s_ans(`CTRB_VAL_HALF_NEG);
  endproperty
  a_half_neg: assert property (p_half_neg)
    else $error("half negative wrong");

  property p_retain_back;
    (take && !WB_WE_I && ret_hit && hlp_wr_vld_r && (idx == hlp_wr_idx_r)) |=>
      WB_ACK_O && (WB_DAT_O[15:0] == hlp_wr_dat_r);
  endproperty
  a_retain_back: assert property (p_retain_back)
    else $error("retain word not read back");

  property p_const_wr;
    (take && WB_WE_I && upper_zero && const_hit) |-> !mem_we ##1 s_ans(16'h0000);
  endproperty
  a_const_wr: assert property (p_const_wr)
    else $error("constant write not ignored");

  property p_unmapped;
    (take && !mapped) |=> (WB_ERR_O && !WB_ACK_O && WB_DAT_O == 32'h0) ##1 s_release;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");

  // ---------------------------------------------------------------
  // handshake and relations between the words
  // ---------------------------------------------------------------
  // relations come from other table values, so one wrong table entry shows twice, except the byte order word, which no relation reads
  sequence s_quiet;
    !WB_ACK_O && !WB_ERR_O && (WB_DAT_O == 32'h00000000);
  endsequence

  property p_answer_next;
    take |=> (WB_ACK_O || WB_ERR_O);
  endproperty
  a_answer_next: assert property (p_answer_next)
    else $error("request not answered in next cycle");

  property p_no_spurious;
    !take |=> (!WB_ACK_O && !WB_ERR_O);
  endproperty
  a_no_spurious: assert property (p_no_spurious)
    else $error("answer without a request");

  property p_dat_idle;
    !WB_ACK_O |-> (WB_DAT_O == 32'h00000000);
  endproperty
  a_dat_idle: assert property (p_dat_idle)
    else $error("read data outside an ack");

  property p_wr_zero;
    (take && WB_WE_I) |=> (WB_DAT_O == 32'h00000000);
  endproperty
  a_wr_zero: assert property (p_wr_zero)
    else $error("write answered with data");

  property p_retain_ack;
    (take && ret_hit) |=> (WB_ACK_O && !WB_ERR_O) ##1 s_release;
  endproperty
  a_retain_ack: assert property (p_retain_ack)
    else $error("retain access not acked for one cycle");

  // a request still held in its ack cycle must not store a second time
  property p_held_once;
    (WB_ACK_O && WB_CYC_I && WB_STB_I) |-> !mem_we;
  endproperty
  a_held_once: assert property (p_held_once)
    else $error("held request taken twice");

  // reset itself is the subject here, so the default disable is off
  property p_reset_out;
    @(posedge CORE_CLK) disable iff (1'b0)
      RESET |=> s_quiet;
  endproperty
  a_reset_out: assert property (p_reset_out)
    else $error("outputs not quiet after reset");

  property p_ones_rel;
    s_rd(`CTRB_IDX_ONES) |=> (WB_DAT_O[15:0] == ~`CTRB_VAL_ZERO);
  endproperty
  a_ones_rel: assert property (p_ones_rel)
    else $error("ones word not inverse of zero word");

  property p_mask_shift;
    s_rd(`CTRB_IDX_MASK_LO) |=> (WB_DAT_O[15:0] == (`CTRB_VAL_MASK_HI >> 1));
  endproperty
  a_mask_shift: assert property (p_mask_shift)
    else $error("low mask not alternating");

  property p_neg_rel;
    s_rd(`CTRB_IDX_MAX_NEG) |=> (WB_DAT_O[15:0] == (`CTRB_VAL_MAX_POS + 16'h0001));
  endproperty
  a_neg_rel: assert property (p_neg_rel)
    else $error("max negative not next to max positive");

  property p_half_pos_rel;
    s_rd(`CTRB_IDX_HALF_POS) |=> (WB_DAT_O[15:0] == (`CTRB_VAL_MAX_POS >> 1));
  endproperty
  a_half_pos_rel: assert property (p_half_pos_rel)
    else $error("half positive not half of max");

  property p_half_neg_rel;
    s_rd(`CTRB_IDX_HALF_NEG) |=>
      ($signed(WB_DAT_O[15:0]) == ($signed(`CTRB_VAL_MAX_NEG) >>> 1));
  endproperty
  a_half_neg_rel: assert property (p_half_neg_rel)
    else $error("half negative not half of min");
endmodule
